// *** bench/crb_host.sv ***
// Host serial reader model
`default_nettype none
module crb_host (
  output logic sclk,
  output logic sel_n,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx [5];
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
  end
  // Clock stands low between frames; sample late in high phase, clear of the shift
  task automatic read_frame(input int n);
    sel_n = 1'b0;
    #640;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        #160 sclk = 1'b1;
        #150 rx[i][b] = sdo;
        #10 sclk = 1'b0;
      end
    end
    #400;
  endtask : read_frame
  task automatic release_sel();
    sel_n = 1'b1;
  endtask : release_sel
endmodule : crb_host
`default_nettype wire

// *** bench/crb_readback_bench.sv ***
// Self-checking bench for the read-back formatter
`default_nettype none
module crb_readback_bench
  import crb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, req_valid, req_ready, sclk, sel_n, pin, oe, busy, done, abrt;
  crb_req_t req;
  logic [1:0] mode;
  logic [7:0] last_integ;
  int error_cnt, checked;
  crb_readback u_crb_readback (.core_clk, .rstn, .req_valid, .req_ready, .req,
    .integrity_mode(mode), .serial_clk_pin(sclk), .select_n_pin(sel_n),
    .serial_out_ready_pin(pin), .serial_out_ready_oe(oe), .busy, .frame_done(done),
    .frame_aborted(abrt), .last_integrity(last_integ));
  crb_host u_crb_host (.sclk, .sel_n, .sdo(pin));
  // ****
  // Shared tasks
  // ****
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp
  task automatic send(input crb_kind_t k, input logic [31:0] w, input logic [1:0] m);
    int n;
    n = 0;
    req_valid = 1'b1;
    req.kind = k;
    req.word = w;
    mode = m;
    while (req_ready !== 1'b1) begin
      n++;
      if (n > 300) begin
        error_cnt++;
        complete_run();
      end
      @(posedge core_clk) #1;
    end
    @(posedge core_clk) #1;
    req_valid = 1'b0;
  endtask : send
  // Deselect and watch for an abort pulse over the synchroniser delay
  task automatic desel(output logic seen);
    seen = 1'b0;
    u_crb_host.release_sel();
    repeat (12) begin
      @(posedge core_clk) #1;
      if (abrt === 1'b1) seen = 1'b1;
    end
  endtask : desel
  // Reference long division; pad byte never enters the dividend
  function automatic logic [7:0] crc_div(input logic [39:0] d);
    for (int i = 39; i >= 8; i--) begin
      if (d[i]) d[i-:9] = d[i-:9] ^ 9'h107;
    end
    return d[7:0];
  endfunction : crc_div
  // ****
  // Scenarios
  // ****
  task automatic frame_chk(input crb_kind_t k, input logic [31:0] w, input logic [1:0] m);
    logic [31:0] d;
    logic [7:0] x;
    logic on, seen;
    int nd;
    nd = (k == KIND_REGISTER) ? 1 : 4;
    d = (k == KIND_PRIMARY) ? w : (k == KIND_AUXILIARY) ? {w[23:0], 8'h00} : {w[7:0], 24'h0};
    on = (k != KIND_REGISTER) && (m == 2'h1 || m == 2'h2);
    x = (m == 2'h1) ? d[31:24] + d[23:16] + d[15:8] + d[7:0] + 8'h9B :
        crc_div((k == KIND_PRIMARY) ? {w, 8'h00} : {8'h00, w[23:0], 8'h00});
    send(k, w, m);
    u_crb_host.read_frame(on ? nd + 1 : nd);
    for (int i = 0; i < nd; i++) cmp(u_crb_host.rx[i], d[31-8*i -: 8]);
    if (on) cmp(u_crb_host.rx[4], x);
    if (on) cmp(last_integ, x);
    cmp(busy, 1'b0);
    desel(seen);
    cmp(seen, 1'b0);
  endtask : frame_chk
  task automatic abort_chk();
    logic seen;
    send(KIND_PRIMARY, 32'hC3A5_5A3C, 2'h2);
    u_crb_host.read_frame(1);
    desel(seen);
    cmp(seen, 1'b1);
    cmp(busy, 1'b0);
  endtask : abort_chk
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    mode = 2'h0;
    error_cnt = 0;
    checked = 0;
    repeat (12) @(posedge core_clk);
    #1 rstn = 1'b1;
    cmp({oe, busy, done, last_integ}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      frame_chk(KIND_PRIMARY, 32'h1234_5678, m[1:0]);
      frame_chk(KIND_AUXILIARY, 32'hFF80_01C3, m[1:0]);
      frame_chk(KIND_REGISTER, 32'h0000_00A6, m[1:0]);
    end
    frame_chk(KIND_AUXILIARY, 32'h0, 2'h1);
    abort_chk();
    frame_chk(KIND_PRIMARY, 32'h8000_0001, 2'h2);
    complete_run();
  end
  initial begin
    #3ms;
    error_cnt++;
    complete_run();
  end
endmodule : crb_readback_bench
`default_nettype wire

// *** bench/crb_readback_props.sv ***
// Port checker for the read-back formatter
`default_nettype none
module crb_readback_props
  import crb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire crb_req_t req,
  input wire logic [1:0] integrity_mode,
  input wire logic serial_clk_pin,
  input wire logic select_n_pin,
  input wire logic serial_out_ready_pin,
  input wire logic serial_out_ready_oe,
  input wire logic busy,
  input wire logic frame_done,
  input wire logic frame_aborted,
  input wire logic [7:0] last_integrity
);
  // ****
  // Port rules
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  done_pulse_a: assert property (frame_done |=> !frame_done)
    else $error("done too long");
  abort_pulse_a: assert property (frame_aborted |=> !frame_aborted)
    else $error("abort too long");
  one_frame_a: assert property (req_valid && req_ready |=> !req_ready)
    else $error("second take");
  oe_follow_a: assert property ($fell(select_n_pin) |-> ##[2:4] serial_out_ready_oe)
    else $error("oe late");
  desel_quiet_a: assert property (select_n_pin [*5]
    |-> !serial_out_ready_oe && !serial_out_ready_pin)
    else $error("pin active unselected");
  integ_busy_a: assert property ($changed(last_integrity) |-> busy)
    else $error("integrity outside frame");
  done_busy_a: assert property (frame_done |-> busy)
    else $error("done while idle");
  reg_single_a: assert property (req_valid && req_ready && !busy && req.kind == KIND_REGISTER
    |-> ##2 frame_done)
    else $error("register frame length");
  ready_idle_a: assert property ((!select_n_pin) [*4] ##0 !busy |-> req_ready)
    else $error("idle not ready");
  cover property (frame_done);
  cover property (frame_aborted);
  cover property (req_valid && req_ready && req.kind == KIND_REGISTER);
endmodule : crb_readback_props
bind crb_readback crb_readback_props u_crb_readback_props (.core_clk, .rstn, .req_valid,
  .req_ready, .req, .integrity_mode, .serial_clk_pin, .select_n_pin, .serial_out_ready_pin,
  .serial_out_ready_oe, .busy, .frame_done, .frame_aborted, .last_integrity);
`default_nettype wire

// *** hdl/crb_fifo.sv ***
// Two-entry byte buffer with valid and ready on both sides
`default_nettype none

module crb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] COUNT_FULL = (PW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } crb_fifo_state_t;

  crb_fifo_state_t s;
  crb_fifo_state_t next_s;
  logic push;
  logic pop;

  assign in_ready = (s.count != COUNT_FULL);
  assign out_valid = (s.count != '0);
  assign out_data = s.mem[s.rptr];

  always_comb begin
    next_s = s;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_s.mem[s.wptr] = in_data;
      next_s.wptr = (s.wptr == PTR_LAST) ? '0 : s.wptr + 1'b1;
    end
    if (pop) begin
      next_s.rptr = (s.rptr == PTR_LAST) ? '0 : s.rptr + 1'b1;
    end
    next_s.count = s.count + (PW + 1)'(push) - (PW + 1)'(pop);
    // Flush drops a frame the host abandoned
    if (flush) begin
      next_s.wptr = '0;
      next_s.rptr = '0;
      next_s.count = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : crb_fifo

`default_nettype wire

// *** hdl/crb_pkg.sv ***
// Shared constants, types and helpers for the conversion read-back formatter
`default_nettype none

package crb_pkg;

  // ****************************************
  // Widths and byte counts
  // ****************************************
  localparam int BYTE_W = 8;
  localparam int PRI_W = 32;
  localparam int AUX_W = 24;
  localparam int BUF_DEPTH = 2;
  localparam logic [2:0] PRI_LAST_DATA = 3'h3;
  localparam logic [2:0] AUX_LAST_DATA = 3'h2;
  localparam logic [2:0] PAD_SLOT = 3'h3;
  localparam logic [2:0] INTEG_SLOT = 3'h4;
  localparam logic [2:0] FIRST_SLOT = 3'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ****************************************
  // Integrity mode field and constants
  // ****************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SUM = 2'h1;
  localparam logic [1:0] MODE_CRC = 2'h2;
  localparam logic [1:0] MODE_RSV = 2'h3;
  localparam logic [7:0] SUM_BIAS = 8'h9B;
  localparam logic [7:0] SUM_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic IDLE_LEVEL = 1'b0;
  localparam logic SEL_IDLE = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {KIND_PRIMARY, KIND_AUXILIARY, KIND_REGISTER} crb_kind_t;

  typedef struct packed {
    crb_kind_t kind;
    logic [PRI_W-1:0] word;
  } crb_req_t;

  // ****************************************
  // Helpers
  // ****************************************
  // One byte of CRC, MSB first; same as long division with eight zero bits appended
  function automatic logic [7:0] crb_crc_byte(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < BYTE_W; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crb_crc_byte

  // True for the result bytes that the integrity byte covers
  function automatic logic crb_counted(input crb_kind_t kind, input logic [2:0] idx);
    return (kind == KIND_PRIMARY && idx <= PRI_LAST_DATA) ||
           (kind == KIND_AUXILIARY && idx <= AUX_LAST_DATA);
  endfunction : crb_counted

  function automatic logic crb_mode_on(input logic [1:0] mode);
    return (mode == MODE_SUM) || (mode == MODE_CRC);
  endfunction : crb_mode_on

endpackage : crb_pkg

`default_nettype wire

// *** hdl/crb_readback.sv ***
// Conversion read-back formatter: result bytes, pad and integrity byte onto the serial pin
`default_nettype none

module crb_readback
  import crb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire crb_req_t req,
  input wire logic [1:0] integrity_mode,
  input wire logic serial_clk_pin,
  input wire logic select_n_pin,
  output logic serial_out_ready_pin,
  output logic serial_out_ready_oe,
  output logic busy,
  output logic frame_done,
  output logic frame_aborted,
  output logic [7:0] last_integrity
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_SEND} crb_seq_t;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic sel_s1;
    logic sel_s2;
    logic sel_s3;
    crb_seq_t st;
    crb_kind_t kind;
    logic [PRI_W-1:0] word;
    logic [1:0] mode;
    logic [2:0] idx;
    logic [7:0] sum;
    logic [7:0] crc;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic pin;
    logic oe;
    logic done;
    logic aborted;
    logic [7:0] integ;
  } crb_state_t;

  crb_state_t s;
  crb_state_t next_s;

  logic buf_in_valid;
  logic buf_in_ready;
  logic [7:0] buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;
  logic abort;

  // ****************************************
  // Byte selection helpers
  // ****************************************
  // Slot index of the last byte of a frame
  function automatic logic [2:0] crb_last_slot(input crb_kind_t kind, input logic on);
    logic [2:0] slot;
    slot = PAD_SLOT;
    if (kind == KIND_REGISTER) begin
      slot = FIRST_SLOT;
    end else if (on) begin
      slot = INTEG_SLOT;
    end
    return slot;
  endfunction : crb_last_slot

  // Result byte for one slot; primary and auxiliary slots past the result carry the pad value, register slots all carry the low byte
  function automatic logic [7:0] crb_result_byte(input crb_kind_t kind,
      input logic [PRI_W-1:0] word, input logic [2:0] idx);
    logic [7:0] b;
    b = PAD_BYTE;
    if (kind == KIND_PRIMARY && idx <= PRI_LAST_DATA) begin
      b = word[PRI_W - 1 - BYTE_W * int'(idx) -: BYTE_W];
    end else if (kind == KIND_AUXILIARY && idx <= AUX_LAST_DATA) begin
      b = word[AUX_W - 1 - BYTE_W * int'(idx) -: BYTE_W];
    end else if (kind == KIND_AUXILIARY) begin
      b = PAD_BYTE;
    end else if (kind == KIND_REGISTER) begin
      b = word[BYTE_W-1:0];
    end
    return b;
  endfunction : crb_result_byte

  // Integrity byte from the running sum or remainder
  function automatic logic [7:0] crb_check_byte(input logic [1:0] mode,
      input logic [7:0] sum, input logic [7:0] crc);
    logic [7:0] b;
    b = crc;
    if (mode == MODE_SUM) begin
      b = sum + SUM_BIAS;
    end
    return b;
  endfunction : crb_check_byte

  // Anything still owed to the host: sequence running or byte not yet shifted
  function automatic logic crb_pending(input crb_seq_t st, input logic [3:0] cnt,
      input logic held);
    return (st != ST_IDLE) || (cnt != '0) || held;
  endfunction : crb_pending

  // A byte sits in the shifter while its bit counter is nonzero
  function automatic logic crb_loaded(input logic [3:0] cnt);
    return cnt != '0;
  endfunction : crb_loaded

  // ****************************************
  // Byte buffer between sequencer and shifter
  // ****************************************
  // A stall by the host leaves the sequencer waiting instead of losing a byte
  crb_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .flush(abort),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic sclk_fall;
    logic selected;
    logic integ_on;
    logic [2:0] last_idx;
    logic [7:0] data_byte;
    logic [7:0] integ_byte;
    logic push;
    logic pop;

    // Locals start defined so no path leaves a latch behind
    sclk_fall = 1'b0;
    selected = 1'b0;
    integ_on = 1'b0;
    last_idx = FIRST_SLOT;
    data_byte = PAD_BYTE;
    integ_byte = SUM_INIT;
    push = 1'b0;
    pop = 1'b0;

    next_s = s;
    next_s.done = 1'b0;
    next_s.aborted = 1'b0;

    // Pins from the host: two stages before any logic looks at them
    next_s.sclk_s1 = serial_clk_pin;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_s3 = s.sclk_s2;
    next_s.sel_s1 = select_n_pin;
    next_s.sel_s2 = s.sel_s1;
    next_s.sel_s3 = s.sel_s2;
    sclk_fall = s.sclk_s3 && !s.sclk_s2;
    selected = !s.sel_s2;
    abort = s.sel_s2 && !s.sel_s3;

    // Integrity byte only in modes 01 and 10, never for registers
    integ_on = crb_mode_on(s.mode) && (s.kind != KIND_REGISTER);
    last_idx = crb_last_slot(s.kind, integ_on);

    // Result bytes pass unaltered, most significant first
    data_byte = crb_result_byte(s.kind, s.word, s.idx);

    integ_byte = crb_check_byte(s.mode, s.sum, s.crc);

    buf_in_valid = (s.st == ST_SEND) && !abort;
    buf_in_data = (integ_on && s.idx == INTEG_SLOT) ? integ_byte : data_byte;
    push = buf_in_valid && buf_in_ready;

    // ****************************************
    // Sequencer
    // ****************************************
    unique case (s.st)
      ST_IDLE: begin
        if (req_valid && !abort) begin
          next_s.st = ST_SEND;
          next_s.kind = req.kind;
          next_s.word = req.word;
          next_s.mode = integrity_mode;
          next_s.idx = FIRST_SLOT;
          next_s.sum = SUM_INIT;
          next_s.crc = CRC_INIT;
        end
      end
      ST_SEND: begin
        if (push) begin
          // Pad byte and integrity byte stay out of the running values
          if (crb_counted(s.kind, s.idx)) begin
            next_s.sum = s.sum + data_byte;
            next_s.crc = crb_crc_byte(s.crc, data_byte);
          end
          if (s.idx == last_idx) begin
            next_s.st = ST_IDLE;
            next_s.done = 1'b1;
            if (integ_on) begin
              next_s.integ = integ_byte;
            end
          end else begin
            next_s.idx = s.idx + 1'b1;
          end
        end
      end
    endcase

    // ****************************************
    // Serial shifter
    // ****************************************
    // Shift on the host's falling edge; host samples late in the high phase
    buf_out_ready = selected && !crb_loaded(s.bit_cnt) && !abort;
    pop = buf_out_ready && buf_out_valid;
    if (pop) begin
      next_s.shift = buf_out_data;
      next_s.bit_cnt = BITS_PER_BYTE;
    end else if (sclk_fall && selected && crb_loaded(s.bit_cnt)) begin
      next_s.shift = {s.shift[6:0], 1'b0};
      next_s.bit_cnt = s.bit_cnt - 1'b1;
    end

    // Deselect mid-frame drops the rest; the host simply reads again
    if (abort) begin
      next_s.st = ST_IDLE;
      next_s.shift = '0;
      next_s.bit_cnt = '0;
      next_s.aborted = crb_pending(s.st, s.bit_cnt, buf_out_valid);
    end

    next_s.pin = crb_loaded(next_s.bit_cnt) ? next_s.shift[7] : IDLE_LEVEL;
    next_s.oe = !s.sel_s2;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s <= '0;
      s.sel_s1 <= SEL_IDLE;
      s.sel_s2 <= SEL_IDLE;
      s.sel_s3 <= SEL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign req_ready = (s.st == ST_IDLE) && !abort;
  assign serial_out_ready_pin = s.pin;
  assign serial_out_ready_oe = s.oe;
  assign busy = crb_pending(s.st, s.bit_cnt, buf_out_valid);
  assign frame_done = s.done;
  assign frame_aborted = s.aborted;
  assign last_integrity = s.integ;

endmodule : crb_readback

`default_nettype wire
